/* logic/csim_cfg.svh */
// Offsets, field positions and reset values of the card socket interrupt block
`ifndef CSIM_CFG_SVH
`define CSIM_CFG_SVH

`define CSIM_LEG_FLAGS_OFS     8'h04
`define CSIM_LEG_MASK_OFS      8'h05
`define CSIM_LEG_GCTL_OFS      8'h1E
`define CSIM_CFG_CARD_CTL_OFS  8'h91
`define CSIM_CFG_DEV_CTL_OFS   8'h92
`define CSIM_SOCK_EVENT_OFS    8'h00
`define CSIM_SOCK_MASK_OFS     8'h04

`define CSIM_GCTL_W1C_BIT      2
`define CSIM_FUNC_FLAG_BIT     0
`define CSIM_SCHEME_LSB        1
`define CSIM_SCHEME_MSB        2
`define CSIM_SCHEME_PAR_ISA    2'h1

`define CSIM_EV_STS_BIT        0
`define CSIM_EV_BATTERY_DETECT_TWO_BIT       1
`define CSIM_EV_READY_BIT      2
`define CSIM_EV_PWR_BIT        3
`define CSIM_EV_CD1_BIT        1
`define CSIM_EV_CD2_BIT        2

`define CSIM_FLAGS_RST         4'h0
`define CSIM_MASK_RST          4'h0
`define CSIM_GCTL_RST          8'h00
`define CSIM_DEVCTL_RST        8'h00

`endif

/* logic/csim_pkg.sv */
// Types shared by the card socket interrupt block
package csim_pkg;

    typedef enum logic [1:0] {
        CSIM_CARD_NONE  = 2'h0,
        CSIM_CARD_MEM16 = 2'h1,
        CSIM_CARD_IO16  = 2'h2,
        CSIM_CARD_CB    = 2'h3
    } csim_card_t;

    typedef enum logic [1:0] {
        CSIM_SP_LEGACY = 2'h0,
        CSIM_SP_CONFIG = 2'h1,
        CSIM_SP_SOCKET = 2'h2,
        CSIM_SP_NONE   = 2'h3
    } csim_space_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        csim_space_t space;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } csim_req_t;

    typedef struct packed {
        logic battery_detect_one;
        logic battery_detect_two;
        logic card_ready;
        logic card_status_change_line;
        logic io_card_interrupt_request;
        logic cb_status_change_line;
        logic cb_card_interrupt;
        logic card_detect_one;
        logic card_detect_two;
        logic cb_card_detect_one;
        logic cb_card_detect_two;
    } csim_pins_t;

endpackage

/* logic/csim_edge.sv */
// Rise and change detector for a group of card socket levels
`timescale 1ns/10ps
module csim_edge #(
    parameter int W = 9
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_change
);
    import csim_pkg::*;

    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;
    logic         primed_q;
    logic         primed_d;

    always_comb
    begin
        prev_d   = i_level;
        primed_d = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            prev_q   <= '0;
            primed_q <= 1'b0;
        end
        else
        begin
            prev_q   <= prev_d;
            primed_q <= primed_d;
        end
    end

    // No events until a first sample is held, so reset release is not a transition
    assign o_rise   = primed_q ? (i_level & ~prev_q) : '0;
    assign o_change = primed_q ? (i_level ^ prev_q) : '0;

endmodule // csim_edge

/* logic/csim_top.sv */
// Card socket interrupt masks, flags and routing to the multifunction pins
//
// Contract
// - Memory card battery-detect transitions set legacy flags 1 and 0, masked by bits 1:0
// - Memory card ready transitions set legacy flag 2, masked by bit 2
// - I/O card status-change assertion sets legacy flag 0, masked by bit 0
// - I/O card interrupt request passes unmasked, reported at config 91h bit 0
// - CardBus card interrupt passes unmasked, reported at config 91h bit 0
// - CardBus status-change assertion sets socket event bit 0, masked by bit 0
// - Any card-detect transition sets socket event bits 2 and 1, masked likewise
// - Power-up completion sets flag bit 3, legacy or socket by card type
// - Functional interrupts only from I/O and CardBus cards, never memory cards
// - Insertion and removal are detected whatever card type is present
// - Every source has a flag; all but functional ones have a mask
// - Status-change and functional interrupts may go to different outputs
// - Legacy flags clear on read or write-one, chosen by global control bit 2
// - Socket event bits clear only on a written one; zero leaves them
// - Parallel IRQ pins are driven only once device control selects that scheme
// - With parallel PCI interrupts, function interrupts go out on pin zero
`timescale 1ns/10ps
`include "csim_cfg.svh"
module csim_top #(
    parameter int PIN_COUNT = 7
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire csim_pkg::csim_req_t   i_req,
    input  wire csim_pkg::csim_card_t  i_card_type,
    input  wire csim_pkg::csim_pins_t  i_pins,
    input  wire logic                  i_power_cycle_done,
    input  wire logic [2:0]            i_func_pin_select,
    output logic [31:0]                o_rd_data,
    output logic                       o_rd_valid,
    output logic [PIN_COUNT-1:0]       o_multifunction_pins,
    output logic [PIN_COUNT-1:0]       o_multifunction_pins_oe
);
    import csim_pkg::*;

    localparam int NLEV = $bits(csim_pins_t);

    function automatic logic hit(input csim_req_t r, input csim_space_t sp,
                                 input logic [7:0] ofs);
        hit = (r.space == sp) && (r.addr == ofs);
    endfunction

    // Level inputs and their transitions
    logic [NLEV-1:0] lev;
    logic [NLEV-1:0] rise;
    logic [NLEV-1:0] change;
    csim_pins_t      rise_s;
    csim_pins_t      chg_s;

    assign lev    = i_pins;
    assign rise_s = rise;
    assign chg_s  = change;

    csim_edge #(
        .W        (NLEV)
    ) u_edge (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_level  (lev),
        .o_rise   (rise),
        .o_change (change)
    );

    // Register state
    logic [3:0]  leg_flags_q;
    logic [3:0]  leg_flags_d;
    logic [3:0]  leg_mask_q;
    logic [3:0]  leg_mask_d;
    logic [7:0]  gctl_q;
    logic [7:0]  gctl_d;
    logic [7:0]  devctl_q;
    logic [7:0]  devctl_d;
    logic [3:0]  sock_ev_q;
    logic [3:0]  sock_ev_d;
    logic [3:0]  sock_mask_q;
    logic [3:0]  sock_mask_d;
    logic [31:0] rd_data_q;
    logic [31:0] rd_data_d;
    logic        rd_valid_q;
    logic        rd_valid_d;
    logic [PIN_COUNT-1:0] mf_q;
    logic [PIN_COUNT-1:0] mf_d;
    logic [PIN_COUNT-1:0] mf_oe_q;
    logic [PIN_COUNT-1:0] mf_oe_d;

    // Event sources
    logic       is_mem;
    logic       is_io;
    logic       is_cb;
    logic [3:0] leg_set;
    logic [3:0] sock_set;
    logic       func_req;

    always_comb
    begin
        is_mem   = (i_card_type == CSIM_CARD_MEM16);
        is_io    = (i_card_type == CSIM_CARD_IO16);
        is_cb    = (i_card_type == CSIM_CARD_CB);
        leg_set  = 4'h0;
        sock_set = 4'h0;
        if (is_mem)
        begin
            leg_set[`CSIM_EV_STS_BIT]   = chg_s.battery_detect_one;
            leg_set[`CSIM_EV_BATTERY_DETECT_TWO_BIT]  = chg_s.battery_detect_two;
            leg_set[`CSIM_EV_READY_BIT] = chg_s.card_ready;
        end
        if (is_io)
        begin
            leg_set[`CSIM_EV_STS_BIT] = rise_s.card_status_change_line;
        end
        if (is_cb)
        begin
            sock_set[`CSIM_EV_STS_BIT] = rise_s.cb_status_change_line;
        end
        // Power-up completion is internal, so it goes to the set of the card present
        leg_set[`CSIM_EV_PWR_BIT]  = i_power_cycle_done & (is_mem | is_io);
        sock_set[`CSIM_EV_PWR_BIT] = i_power_cycle_done & is_cb;
        // Detect lines are watched with no card-type gate: the type is unknown mid-insert
        sock_set[`CSIM_EV_CD1_BIT] = chg_s.card_detect_one | chg_s.cb_card_detect_one;
        sock_set[`CSIM_EV_CD2_BIT] = chg_s.card_detect_two | chg_s.cb_card_detect_two;
        // Functional requests are levels with no mask; memory cards never raise one
        func_req = (is_io & i_pins.io_card_interrupt_request)
                 | (is_cb & i_pins.cb_card_interrupt);
    end

    // Register writes, flag clears and read data
    logic        wr_leg_flags;
    logic        rd_leg_flags;
    logic        w1c_mode;
    logic [3:0]  leg_clr;
    logic [3:0]  sock_clr;

    always_comb
    begin
        wr_leg_flags = i_req.wr & hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_FLAGS_OFS);
        rd_leg_flags = i_req.rd & hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_FLAGS_OFS);
        w1c_mode     = gctl_q[`CSIM_GCTL_W1C_BIT];
        leg_clr      = 4'h0;
        if (w1c_mode && wr_leg_flags)
        begin
            leg_clr = i_req.wdata[3:0];
        end
        else if (!w1c_mode && rd_leg_flags)
        begin
            leg_clr = 4'hF;
        end
        sock_clr = 4'h0;
        if (i_req.wr && hit(i_req, CSIM_SP_SOCKET, `CSIM_SOCK_EVENT_OFS))
        begin
            sock_clr = i_req.wdata[3:0];
        end

        // A new event in the clearing cycle survives the clear
        leg_flags_d = (leg_flags_q & ~leg_clr) | leg_set;
        sock_ev_d   = (sock_ev_q & ~sock_clr) | sock_set;

        leg_mask_d  = leg_mask_q;
        gctl_d      = gctl_q;
        devctl_d    = devctl_q;
        sock_mask_d = sock_mask_q;
        // Both register sets stay independent; mixed use is left to software
        if (i_req.wr)
        begin
            if (hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_MASK_OFS))
            begin
                leg_mask_d = i_req.wdata[3:0];
            end
            if (hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_GCTL_OFS))
            begin
                gctl_d = i_req.wdata[7:0];
            end
            if (hit(i_req, CSIM_SP_CONFIG, `CSIM_CFG_DEV_CTL_OFS))
            begin
                devctl_d = i_req.wdata[7:0];
            end
            if (hit(i_req, CSIM_SP_SOCKET, `CSIM_SOCK_MASK_OFS))
            begin
                sock_mask_d = i_req.wdata[3:0];
            end
        end
    end

    // Read port, apart from the flag logic so the returned value is the pre-clear one
    always_comb
    begin
        // Unmapped addresses read as zero
        rd_data_d  = 32'h0000_0000;
        rd_valid_d = i_req.rd;
        if (i_req.rd)
        begin
            if (rd_leg_flags)
            begin
                rd_data_d[3:0] = leg_flags_q;
            end
            else if (hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_MASK_OFS))
            begin
                rd_data_d[3:0] = leg_mask_q;
            end
            else if (hit(i_req, CSIM_SP_LEGACY, `CSIM_LEG_GCTL_OFS))
            begin
                rd_data_d[7:0] = gctl_q;
            end
            else if (hit(i_req, CSIM_SP_CONFIG, `CSIM_CFG_CARD_CTL_OFS))
            begin
                rd_data_d[`CSIM_FUNC_FLAG_BIT] = func_req;
            end
            else if (hit(i_req, CSIM_SP_CONFIG, `CSIM_CFG_DEV_CTL_OFS))
            begin
                rd_data_d[7:0] = devctl_q;
            end
            else if (hit(i_req, CSIM_SP_SOCKET, `CSIM_SOCK_EVENT_OFS))
            begin
                rd_data_d[3:0] = sock_ev_q;
            end
            else if (hit(i_req, CSIM_SP_SOCKET, `CSIM_SOCK_MASK_OFS))
            begin
                rd_data_d[3:0] = sock_mask_q;
            end
        end
    end

    // Interrupt routing
    logic       csc_irq;
    logic       par_isa;
    logic [2:0] func_pin;

    always_comb
    begin
        csc_irq = |(leg_flags_q & leg_mask_q) | |(sock_ev_q & sock_mask_q);
        par_isa = (devctl_q[`CSIM_SCHEME_MSB:`CSIM_SCHEME_LSB] == `CSIM_SCHEME_PAR_ISA);
        // A select out of range falls back to pin zero rather than a missing pin
        func_pin = (i_func_pin_select < 3'(PIN_COUNT)) ? i_func_pin_select : 3'h0;
        mf_d    = '0;
        mf_oe_d = '0;
        mf_d[0]    = csc_irq;
        // Pin zero is driven in every scheme: status change always needs INTA
        mf_oe_d[0] = 1'b1;
        if (par_isa)
        begin
            mf_oe_d[func_pin] = 1'b1;
            mf_d[func_pin]    = mf_d[func_pin] | func_req;
        end
        else
        begin
            mf_d[0] = csc_irq | func_req;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            leg_flags_q <= `CSIM_FLAGS_RST;
            leg_mask_q  <= `CSIM_MASK_RST;
            gctl_q      <= `CSIM_GCTL_RST;
            devctl_q    <= `CSIM_DEVCTL_RST;
            sock_ev_q   <= `CSIM_FLAGS_RST;
            sock_mask_q <= `CSIM_MASK_RST;
        end
        else
        begin
            leg_flags_q <= leg_flags_d;
            leg_mask_q  <= leg_mask_d;
            gctl_q      <= gctl_d;
            devctl_q    <= devctl_d;
            sock_ev_q   <= sock_ev_d;
            sock_mask_q <= sock_mask_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rd_data_q  <= 32'h0000_0000;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Pin drive stays off through reset, so the host sees no request from a half-reset block
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mf_q    <= '0;
            mf_oe_q <= '0;
        end
        else
        begin
            mf_q    <= mf_d;
            mf_oe_q <= mf_oe_d;
        end
    end

    assign o_rd_data               = rd_data_q;
    assign o_rd_valid              = rd_valid_q;
    assign o_multifunction_pins    = mf_q;
    assign o_multifunction_pins_oe = mf_oe_q;

endmodule // csim_top

/* verification/csim_card_model.sv */
// Socket-side model: presents the card lines to the bridge on its clock
`timescale 1ns/10ps
module csim_card_model (
    input  wire logic                 i_clk,
    input  wire csim_pkg::csim_pins_t i_want,
    output csim_pkg::csim_pins_t      o_pins
);
    import csim_pkg::*;
    // Lines move just after an edge only, so the bridge never samples a half change
    always_ff @(posedge i_clk)
        o_pins <= i_want;
endmodule // csim_card_model

/* verification/csim_top_sva.sv */
// Port assertions for the card socket interrupt block
`timescale 1ns/10ps
module csim_top_sva #(
    parameter int PIN_COUNT = 7
) (
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    input wire csim_pkg::csim_req_t  i_req,
    input wire csim_pkg::csim_card_t i_card_type,
    input wire csim_pkg::csim_pins_t i_pins,
    input wire logic                 i_power_cycle_done,
    input wire logic [2:0]           i_func_pin_select,
    input wire logic [31:0]          o_rd_data,
    input wire logic                 o_rd_valid,
    input wire logic [PIN_COUNT-1:0] o_multifunction_pins,
    input wire logic [PIN_COUNT-1:0] o_multifunction_pins_oe
);
    import csim_pkg::*;
    logic isa_q;
    logic isa_d;
    logic func;
    // Shadow of the scheme field, so pin drive can be judged from the ports alone
    always_comb
    begin
        isa_d = isa_q;
        if (i_req.wr && i_req.space == CSIM_SP_CONFIG && i_req.addr == 8'h92)
            isa_d = (i_req.wdata[2:1] == 2'h1);
        func = (i_card_type == CSIM_CARD_IO16 && i_pins.io_card_interrupt_request)
            || (i_card_type == CSIM_CARD_CB && i_pins.cb_card_interrupt);
    end
    always_ff @(posedge i_clk)
        isa_q <= i_sys_rst ? 1'b0 : isa_d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_read_answered: assert property (i_req.rd |=> o_rd_valid)
        else $error("read not answered one cycle later");
    a_valid_has_cause: assert property (o_rd_valid |-> $past(i_req.rd))
        else $error("read valid without a read");
    a_pin_zero_driven: assert property (!$past(i_sys_rst) |-> o_multifunction_pins_oe[0])
        else $error("pin zero not driven");
    a_func_on_zero: assert property (func && i_func_pin_select == 3'h0
        |=> o_multifunction_pins[0]) else $error("functional request missing on pin zero");
    a_isa_oe_off: assert property (!isa_q && !$past(isa_q)
        |-> o_multifunction_pins_oe[PIN_COUNT-1:1] == '0) else $error("pins driven early");
    a_unmapped_zero: assert property (i_req.rd && i_req.space == CSIM_SP_NONE
        |=> o_rd_data == 32'h0) else $error("unmapped read not zero");
    a_func_flag_live: assert property (i_req.rd && i_req.space == CSIM_SP_CONFIG
        && i_req.addr == 8'h91 |=> o_rd_data == {31'h0, $past(func)})
        else $error("functional flag wrong");
    a_flag_width: assert property (i_req.rd && i_req.space == CSIM_SP_LEGACY
        && i_req.addr == 8'h04 |=> o_rd_data[31:4] == 28'h0) else $error("flag upper bits set");
endmodule // csim_top_sva
bind csim_top csim_top_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_card_type(i_card_type),
    .i_pins(i_pins), .i_power_cycle_done(i_power_cycle_done),
    .i_func_pin_select(i_func_pin_select), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_multifunction_pins(o_multifunction_pins),
    .o_multifunction_pins_oe(o_multifunction_pins_oe));

/* verification/csim_top_bench.sv */
// Self-checking bench for the card socket interrupt block
`timescale 1ns/10ps
module csim_top_bench;
    import csim_pkg::*;
    typedef struct packed {
        csim_card_t  t;
        csim_pins_t  p;
        csim_space_t s;
        logic [7:0]  a;
        logic [31:0] e;
    } csim_row_t;
    logic        i_clk;
    logic        i_sys_rst;
    csim_req_t   req;
    csim_card_t  card;
    csim_pins_t  want;
    csim_pins_t  pins;
    logic        pwr;
    logic [2:0]  fsel;
    logic [31:0] rdat;
    logic        rval;
    logic [6:0]  mf;
    logic [6:0]  mf_oe;
    logic [31:0] got;
    int          n_fail;
    int          samples_checked;
    csim_row_t   rows [16];
    csim_card_model u_card (.i_clk(i_clk), .i_want(want), .o_pins(pins));
    csim_top #(.PIN_COUNT(7)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_card_type(card),
        .i_pins(pins), .i_power_cycle_done(pwr), .i_func_pin_select(fsel),
        .o_rd_data(rdat), .o_rd_valid(rval), .o_multifunction_pins(mf),
        .o_multifunction_pins_oe(mf_oe));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr(input csim_space_t s, input logic [7:0] a, input logic [31:0] d);
        req = '{1'b1, 1'b0, s, a, d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask
    task automatic rc(input string n, input csim_space_t s, input logic [7:0] a,
                      input logic [31:0] e);
        req = '{1'b0, 1'b1, s, a, 32'h0};
        cyc(1);
        chk("read valid", 32'h1, {31'h0, rval});
        chk(n, e, rdat);
        req = '0;
        cyc(1);
    endtask
    task results;
        $display("checked %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (100000) @(posedge i_clk);
        n_fail++;
        results();
    end
    initial
    begin
        i_sys_rst = 1'b1;
        req = '0;
        card = CSIM_CARD_NONE;
        want = '0;
        pwr = 1'b0;
        fsel = 3'h0;
        n_fail = 0;
        samples_checked = 0;
        rows = '{
            '{CSIM_CARD_NONE, 11'h0, CSIM_SP_LEGACY, 8'h05, 32'h0},
            '{CSIM_CARD_NONE, 11'h0, CSIM_SP_LEGACY, 8'h1E, 32'h0},
            '{CSIM_CARD_NONE, 11'h0, CSIM_SP_CONFIG, 8'h92, 32'h0},
            '{CSIM_CARD_NONE, 11'h0, CSIM_SP_SOCKET, 8'h04, 32'h0},
            '{CSIM_CARD_NONE, 11'h0, CSIM_SP_NONE, 8'h00, 32'h0},
            '{CSIM_CARD_MEM16, 11'h400, CSIM_SP_LEGACY, 8'h04, 32'h1},
            '{CSIM_CARD_MEM16, 11'h200, CSIM_SP_LEGACY, 8'h04, 32'h2},
            '{CSIM_CARD_MEM16, 11'h100, CSIM_SP_LEGACY, 8'h04, 32'h4},
            '{CSIM_CARD_MEM16, 11'h80, CSIM_SP_LEGACY, 8'h04, 32'h0},
            '{CSIM_CARD_IO16, 11'h80, CSIM_SP_LEGACY, 8'h04, 32'h1},
            '{CSIM_CARD_CB, 11'h20, CSIM_SP_SOCKET, 8'h00, 32'h1},
            '{CSIM_CARD_NONE, 11'h8, CSIM_SP_SOCKET, 8'h00, 32'h2},
            '{CSIM_CARD_MEM16, 11'h4, CSIM_SP_SOCKET, 8'h00, 32'h4},
            '{CSIM_CARD_IO16, 11'h40, CSIM_SP_CONFIG, 8'h91, 32'h1},
            '{CSIM_CARD_CB, 11'h10, CSIM_SP_CONFIG, 8'h91, 32'h1},
            '{CSIM_CARD_MEM16, 11'h40, CSIM_SP_CONFIG, 8'h91, 32'h0}};
        cyc(8);
        i_sys_rst = 1'b0;
        cyc(2);
        foreach (rows[i])
        begin
            card = rows[i].t;
            want = rows[i].p;
            cyc(5);
            rc("row flags", rows[i].s, rows[i].a, rows[i].e);
            want = '0;
            card = CSIM_CARD_NONE;
            cyc(5);
            rc("idle flags", CSIM_SP_LEGACY, 8'h04, 32'h0);
            wr(CSIM_SP_SOCKET, 8'h00, 32'hF);
            $display("row %0d done", i);
        end
        card = CSIM_CARD_MEM16;
        pwr = 1'b1;
        cyc(1);
        pwr = 1'b0;
        cyc(3);
        rc("power legacy", CSIM_SP_LEGACY, 8'h04, 32'h8);
        card = CSIM_CARD_CB;
        pwr = 1'b1;
        cyc(1);
        pwr = 1'b0;
        cyc(3);
        rc("power socket", CSIM_SP_SOCKET, 8'h00, 32'h8);
        wr(CSIM_SP_SOCKET, 8'h00, 32'h8);
        $display("power test done");
        wr(CSIM_SP_LEGACY, 8'h1E, 32'h4);
        rc("global control", CSIM_SP_LEGACY, 8'h1E, 32'h4);
        card = CSIM_CARD_MEM16;
        want = 11'h408;
        cyc(5);
        rc("read keeps", CSIM_SP_LEGACY, 8'h04, 32'h1);
        wr(CSIM_SP_LEGACY, 8'h04, 32'h0);
        wr(CSIM_SP_SOCKET, 8'h00, 32'h0);
        rc("zero keeps", CSIM_SP_LEGACY, 8'h04, 32'h1);
        rc("zero keeps socket", CSIM_SP_SOCKET, 8'h00, 32'h2);
        wr(CSIM_SP_LEGACY, 8'h04, 32'h1);
        wr(CSIM_SP_SOCKET, 8'h00, 32'h2);
        rc("one clears", CSIM_SP_LEGACY, 8'h04, 32'h0);
        rc("one clears socket", CSIM_SP_SOCKET, 8'h00, 32'h0);
        want = '0;
        card = CSIM_CARD_NONE;
        cyc(5);
        wr(CSIM_SP_SOCKET, 8'h00, 32'hF);
        wr(CSIM_SP_LEGACY, 8'h1E, 32'h0);
        $display("clear test done");
        card = CSIM_CARD_MEM16;
        want = 11'h400;
        cyc(5);
        chk("pin0 masked", 32'h0, {31'h0, mf[0]});
        wr(CSIM_SP_LEGACY, 8'h05, 32'h1);
        cyc(2);
        chk("pin0 raised", 32'h1, {31'h0, mf[0]});
        wr(CSIM_SP_LEGACY, 8'h04, 32'h1);
        rc("flags", CSIM_SP_LEGACY, 8'h04, 32'h1);
        cyc(2);
        chk("pin0 dropped", 32'h0, {31'h0, mf[0]});
        wr(CSIM_SP_LEGACY, 8'h05, 32'h0);
        want = '0;
        card = CSIM_CARD_NONE;
        cyc(5);
        want = 11'h8;
        cyc(5);
        chk("pin0 socket masked", 32'h0, {31'h0, mf[0]});
        wr(CSIM_SP_SOCKET, 8'h04, 32'h2);
        cyc(2);
        chk("pin0 socket raised", 32'h1, {31'h0, mf[0]});
        rc("socket mask", CSIM_SP_SOCKET, 8'h04, 32'h2);
        wr(CSIM_SP_SOCKET, 8'h00, 32'h2);
        cyc(2);
        chk("pin0 socket dropped", 32'h0, {31'h0, mf[0]});
        wr(CSIM_SP_SOCKET, 8'h04, 32'h0);
        want = '0;
        cyc(5);
        wr(CSIM_SP_SOCKET, 8'h00, 32'hF);
        $display("mask test done");
        fsel = 3'h3;
        card = CSIM_CARD_IO16;
        want = 11'h40;
        cyc(5);
        chk("pci pins", 32'h81, {18'h0, mf_oe, mf});
        wr(CSIM_SP_CONFIG, 8'h92, 32'h2);
        cyc(2);
        chk("isa pins", 32'h488, {18'h0, mf_oe, mf});
        fsel = 3'h7;
        cyc(2);
        chk("isa fallback", 32'h81, {18'h0, mf_oe, mf});
        rc("scheme", CSIM_SP_CONFIG, 8'h92, 32'h2);
        wr(CSIM_SP_CONFIG, 8'h92, 32'h0);
        want = '0;
        card = CSIM_CARD_NONE;
        fsel = 3'h0;
        cyc(3);
        $display("routing test done");
        // Set against clear in one cycle, then a mid-run reset with the line held high
        fsel = 3'h3;
        wr(CSIM_SP_LEGACY, 8'h05, 32'hF);
        wr(CSIM_SP_CONFIG, 8'h92, 32'h2);
        card = CSIM_CARD_MEM16;
        want = 11'h400;
        cyc(1);
        rc("clear edge", CSIM_SP_LEGACY, 8'h04, 32'h0);
        rc("set wins", CSIM_SP_LEGACY, 8'h04, 32'h1);
        chk("isa oe", 32'h480, {18'h0, mf_oe, mf});
        i_sys_rst = 1'b1;
        cyc(2);
        chk("pins in reset", 32'h0, {18'h0, mf_oe, mf});
        i_sys_rst = 1'b0;
        cyc(1);
        chk("pins at release", 32'h80, {18'h0, mf_oe, mf});
        cyc(2);
        rc("no reset event", CSIM_SP_LEGACY, 8'h04, 32'h0);
        rc("mask reset", CSIM_SP_LEGACY, 8'h05, 32'h0);
        rc("scheme reset", CSIM_SP_CONFIG, 8'h92, 32'h0);
        want = '0;
        card = CSIM_CARD_NONE;
        fsel = 3'h0;
        cyc(3);
        $display("reset test done");
        results();
    end
endmodule // csim_top_bench
